//--- core/core_debug_controller.v
// Added by the designer: the register addresses and register access over APB.
`timescale 1ns/1ns
`include "dbg_ctrl_map.vh"
// Notes on behaviour
// - debug enable bit 0 disables controller; 1 enables debug mode
// - events arise only while the controller is enabled
// - break-in event performs action from external event config
// - external event stops core without reset, independent of instructions
// - external event recognition may wait while a non-cancellable instruction runs
// - break-out driven by events only; software cannot write it
// - suspend-out follows status suspend field, including software writes
// - debug instruction raises event when enabled, else no-op
// - short and long debug instruction encodings behave identically
// - debug instruction event uses software event config action
// - core-register move raises event when enabled
// - trigger unit events are a further event source
// - each event updates status and may signal, halt, trap, interrupt, count
// - hardware single-step support
// - registers accessible over APB while core runs, minimal intrusion
// - detection does not disturb execution; config writable while running
// - no event for moves into the dedicated debug register range
// - each event except interrupt action copies suspend to previous-suspend, then loads source suspend
// - halt entered with field 01; cleared by writing 10
// - software suspend write leaves previous-suspend unchanged
module core_debug_controller (
	input wire clk_in,
	input wire nrst_in,
	input wire psel_in,
	input wire penable_in,
	input wire pwrite_in,
	input wire [11:0] paddr_in,
	input wire [31:0] pwdata_in,
	output reg [31:0] prdata_out,
	output reg pready_out,
	output reg pslverr_out,
	input wire break_in_in,
	input wire suspend_in_in,
	input wire trigger_event_in,
	input wire noncancel_busy_in,
	input wire instr_valid_in,
	input wire instr_long_in,
	input wire [31:0] instr_in,
	input wire cr_move_in,
	input wire [15:0] cr_addr_in,
	input wire instr_retired_in,
	output reg break_out_out,
	output reg suspend_out_out,
	output reg halt_out,
	output reg trap_out,
	output reg bp_int_out,
	output reg count_run_out,
	output reg debug_mode_out
);
	////////////////////////////////////////////////////////////////////////
	reg de_reg;
	reg [1:0] halt_reg;
	reg suspend_field_reg;
	reg previous_suspend_field_reg;
	reg pevt_reg;
	reg [3:0] src_reg;
	reg [5:0] ext_cfg_reg;
	reg [5:0] sw_cfg_reg;
	reg [5:0] cr_cfg_reg;
	reg [5:0] trig_cfg_reg;
	reg step_reg;
	reg brk_s1_reg, brk_s2_reg, brk_s3_reg;
	reg sin_s1_reg, sin_s2_reg, sin_s3_reg;
	reg ext_pend_reg;
	reg sin_pend_reg;
	wire sw_evt;
	wire cr_evt;
	wire wr_acc;
	wire rd_acc;
	wire ext_fire;
	reg any_evt;
	reg [3:0] src_next;
	reg [5:0] cfg_sel;
	reg [31:0] status_word;
	reg [31:0] rd_word;
	reg rd_err;

	dbg_event_detect u_detect (
		.clk_in(clk_in),
		.nrst_in(nrst_in),
		.enable_in(de_reg),
		.instr_valid_in(instr_valid_in),
		.instr_long_in(instr_long_in),
		.instr_in(instr_in),
		.cr_move_in(cr_move_in),
		.cr_addr_in(cr_addr_in),
		.sw_event_out(sw_evt),
		.cr_event_out(cr_evt)
	);

	////////////////////////////////////////////////////////////////////////
	// apb: single-wait-free slave, answers in the access cycle
	assign wr_acc = psel_in && penable_in && pwrite_in;
	assign rd_acc = psel_in && penable_in && !pwrite_in;

	always @* begin
		status_word = 32'h0000_0000;
		status_word[`ST_DE_BIT] = de_reg;
		status_word[`ST_HALT_LSB+1:`ST_HALT_LSB] = halt_reg;
		status_word[`ST_SUSPEND_FIELD_BIT] = suspend_field_reg;
		status_word[`ST_PREVIOUS_SUSPEND_FIELD_BIT] = previous_suspend_field_reg;
		status_word[`ST_PEVT_BIT] = pevt_reg;
		status_word[`ST_SRC_LSB+3:`ST_SRC_LSB] = src_reg;
		status_word[`ST_SUSPIN_BIT] = sin_s2_reg;
	end

	// read mux; unmapped or unaligned offsets answer zero with an error
	always @* begin
		rd_word = 32'h0000_0000;
		rd_err = 1'b0;
		case (paddr_in)
		`OFF_STATUS: rd_word = status_word;
		`OFF_EXT_CFG: rd_word = {26'h0, ext_cfg_reg};
		`OFF_SW_CFG: rd_word = {26'h0, sw_cfg_reg};
		`OFF_CR_CFG: rd_word = {26'h0, cr_cfg_reg};
		`OFF_TRIG_CFG: rd_word = {26'h0, trig_cfg_reg};
		`OFF_STEP: rd_word = {31'h0, step_reg};
		default: rd_err = 1'b1;
		endcase
	end

	always @(posedge clk_in) begin
		if (!nrst_in) begin
			prdata_out <= 32'h0000_0000;
			pready_out <= 1'b0;
			pslverr_out <= 1'b0;
		end else begin
			pready_out <= psel_in && !penable_in;
			pslverr_out <= 1'b0;
			if (psel_in && !penable_in) begin
				prdata_out <= rd_word;
				pslverr_out <= rd_err;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// pin synchronisers; third stage only for edge detect
	always @(posedge clk_in) begin
		if (!nrst_in) begin
			brk_s1_reg <= 1'b0;
			brk_s2_reg <= 1'b0;
			brk_s3_reg <= 1'b0;
			sin_s1_reg <= 1'b0;
			sin_s2_reg <= 1'b0;
			sin_s3_reg <= 1'b0;
		end else begin
			brk_s1_reg <= break_in_in;
			brk_s2_reg <= brk_s1_reg;
			brk_s3_reg <= brk_s2_reg;
			sin_s1_reg <= suspend_in_in;
			sin_s2_reg <= sin_s1_reg;
			sin_s3_reg <= sin_s2_reg;
		end
	end

	// pending latches: recognition waits out non-cancellable work
	assign ext_fire = ext_pend_reg && !noncancel_busy_in;

	always @(posedge clk_in) begin
		if (!nrst_in) begin
			ext_pend_reg <= 1'b0;
			sin_pend_reg <= 1'b0;
		end else begin
			if (de_reg && brk_s2_reg && !brk_s3_reg)
				ext_pend_reg <= 1'b1;
			else if (ext_fire || !de_reg)
				ext_pend_reg <= 1'b0;
			if (de_reg && sin_s2_reg && !sin_s3_reg)
				sin_pend_reg <= 1'b1;
			else if (!noncancel_busy_in || !de_reg)
				sin_pend_reg <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// fixed priority: external, software, core register, trigger
	always @* begin
		any_evt = 1'b1;
		src_next = `SRC_NONE;
		cfg_sel = 6'h00;
		if (ext_fire) begin
			src_next = `SRC_EXT;
			cfg_sel = ext_cfg_reg;
		end else if (sw_evt) begin
			src_next = `SRC_SW;
			cfg_sel = sw_cfg_reg;
		end else if (cr_evt) begin
			src_next = `SRC_CR;
			cfg_sel = cr_cfg_reg;
		end else if (de_reg && trigger_event_in) begin
			src_next = `SRC_TRIG;
			cfg_sel = trig_cfg_reg;
		end else begin
			any_evt = 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// register file and event actions; software writes never stall the core
	wire wr_status;
	wire wr_ext_cfg;
	wire wr_sw_cfg;
	wire wr_cr_cfg;
	wire wr_trig_cfg;
	wire wr_step;
	wire [2:0] act_sel;
	wire act_evt;
	wire act_int;
	wire step_halt;
	wire sin_halt;

	assign wr_status = wr_acc && (paddr_in == `OFF_STATUS);
	assign wr_ext_cfg = wr_acc && (paddr_in == `OFF_EXT_CFG);
	assign wr_sw_cfg = wr_acc && (paddr_in == `OFF_SW_CFG);
	assign wr_cr_cfg = wr_acc && (paddr_in == `OFF_CR_CFG);
	assign wr_trig_cfg = wr_acc && (paddr_in == `OFF_TRIG_CFG);
	assign wr_step = wr_acc && (paddr_in == `OFF_STEP);
	assign act_sel = cfg_sel[`CFG_EVENT_ACTION_FIELD_LSB+2:`CFG_EVENT_ACTION_FIELD_LSB];
	// a source set to disabled is dropped, and it still masks lower-priority sources firing in the same cycle
	assign act_evt = any_evt && (act_sel != `EVENT_ACTION_FIELD_DISABLED);
	// interrupt action keeps both suspend fields untouched
	assign act_int = (act_sel == `EVENT_ACTION_FIELD_INT);
	// single step: each retired instruction halts again
	assign step_halt = de_reg && step_reg && instr_retired_in && (halt_reg == `HALT_RUN);
	assign sin_halt = sin_pend_reg && !noncancel_busy_in;

	////////////////////////////////////////////////////////////////////////
	// configuration registers: written by software only
	always @(posedge clk_in) begin
		if (!nrst_in) begin
			ext_cfg_reg <= 6'h00;
			sw_cfg_reg <= 6'h00;
			cr_cfg_reg <= 6'h00;
			trig_cfg_reg <= 6'h00;
			step_reg <= 1'b0;
		end else begin
			if (wr_ext_cfg)
				ext_cfg_reg <= pwdata_in[5:0];
			if (wr_sw_cfg)
				sw_cfg_reg <= pwdata_in[5:0];
			if (wr_cr_cfg)
				cr_cfg_reg <= pwdata_in[5:0];
			if (wr_trig_cfg)
				trig_cfg_reg <= pwdata_in[5:0];
			if (wr_step)
				step_reg <= pwdata_in[0];
		end
	end

	always @(posedge clk_in) begin
		if (!nrst_in) begin
			de_reg <= 1'b0;
		end else begin
			if (wr_status)
				de_reg <= pwdata_in[`ST_DE_BIT];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// halt field: later lines win, so any halt request beats a software clear
	always @(posedge clk_in) begin
		if (!nrst_in) begin
			halt_reg <= `HALT_RUN;
		end else begin
			if (wr_status && pwdata_in[`ST_HALT_LSB+1:`ST_HALT_LSB] == `HALT_CLR)
				halt_reg <= `HALT_RUN;
			if (step_halt)
				halt_reg <= `HALT_ON;
			if (sin_halt)
				halt_reg <= `HALT_ON;
			if (act_evt && act_sel == `EVENT_ACTION_FIELD_HALT)
				halt_reg <= `HALT_ON;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// suspend, previous suspend, posted event and source
	always @(posedge clk_in) begin
		if (!nrst_in) begin
			suspend_field_reg <= 1'b0;
			previous_suspend_field_reg <= 1'b0;
			pevt_reg <= 1'b0;
			src_reg <= `SRC_NONE;
		end else begin
			if (wr_status) begin
				suspend_field_reg <= pwdata_in[`ST_SUSPEND_FIELD_BIT];
				pevt_reg <= 1'b0;
			end
			// event set wins over a software write in the same cycle, except that under the interrupt action the written suspend field is kept
			if (act_evt) begin
				src_reg <= src_next;
				pevt_reg <= 1'b1;
				if (!act_int) begin
					previous_suspend_field_reg <= suspend_field_reg;
					suspend_field_reg <= cfg_sel[`CFG_SUSPEND_FIELD_BIT];
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// action pulses and the count-run toggle towards the core and the debug support side
	always @(posedge clk_in) begin
		if (!nrst_in) begin
			break_out_out <= 1'b0;
			trap_out <= 1'b0;
			bp_int_out <= 1'b0;
			count_run_out <= 1'b0;
		end else begin
			break_out_out <= act_evt && cfg_sel[`CFG_BOD_BIT];
			trap_out <= act_evt && (act_sel == `EVENT_ACTION_FIELD_TRAP);
			bp_int_out <= act_evt && act_int;
			// counters only toggle: start and stop share one bit
			if (act_evt && cfg_sel[`CFG_CNT_BIT])
				count_run_out <= !count_run_out;
		end
	end

	// status mirrors, registered so every output leaves a flip-flop
	always @(posedge clk_in) begin
		if (!nrst_in) begin
			suspend_out_out <= 1'b0;
			halt_out <= 1'b0;
			debug_mode_out <= 1'b0;
		end else begin
			suspend_out_out <= suspend_field_reg;
			halt_out <= (halt_reg == `HALT_ON);
			debug_mode_out <= de_reg;
		end
	end
endmodule

//--- core/dbg_ctrl_map.vh
`ifndef DBG_CTRL_MAP_VH
`define DBG_CTRL_MAP_VH

// register byte offsets
`define OFF_STATUS 12'h000
`define OFF_EXT_CFG 12'h004
`define OFF_SW_CFG 12'h008
`define OFF_CR_CFG 12'h00c
`define OFF_TRIG_CFG 12'h010
`define OFF_STEP 12'h014

// status fields
`define ST_DE_BIT 0
`define ST_HALT_LSB 1
`define ST_SUSPEND_FIELD_BIT 3
`define ST_PREVIOUS_SUSPEND_FIELD_BIT 4
`define ST_PEVT_BIT 5
`define ST_SRC_LSB 8
`define ST_SUSPIN_BIT 12

// config register fields (external, software, core-register, trigger)
`define CFG_EVENT_ACTION_FIELD_LSB 0
`define CFG_BOD_BIT 3
`define CFG_SUSPEND_FIELD_BIT 4
`define CFG_CNT_BIT 5

// event action encodings
`define EVENT_ACTION_FIELD_NONE 3'h0
`define EVENT_ACTION_FIELD_DISABLED 3'h1
`define EVENT_ACTION_FIELD_HALT 3'h2
`define EVENT_ACTION_FIELD_TRAP 3'h3
`define EVENT_ACTION_FIELD_INT 3'h4

// halt field values
`define HALT_RUN 2'h0
`define HALT_ON 2'h1
`define HALT_CLR 2'h2

// event source codes
`define SRC_NONE 4'h0
`define SRC_EXT 4'h1
`define SRC_SW 4'h2
`define SRC_CR 4'h3
`define SRC_TRIG 4'h4

// dedicated debug register range
`define DBG_RANGE_LO 16'hf000
`define DBG_RANGE_HI 16'hfdff

// software debug instruction encodings
`define SW_DBG_SHORT 16'ha000
`define SW_DBG_LONG 32'h0100_000d

`endif

//--- core/dbg_event_detect.v
`timescale 1ns/1ns
`include "dbg_ctrl_map.vh"
// decodes instruction-driven event sources
module dbg_event_detect (
	input wire clk_in,
	input wire nrst_in,
	input wire enable_in,
	input wire instr_valid_in,
	input wire instr_long_in,
	input wire [31:0] instr_in,
	input wire cr_move_in,
	input wire [15:0] cr_addr_in,
	output reg sw_event_out,
	output reg cr_event_out
);
	wire sw_hit;
	wire cr_hit;
	wire in_dbg_range;

	assign sw_hit = instr_long_in ? (instr_in == `SW_DBG_LONG) : (instr_in[15:0] == `SW_DBG_SHORT);
	assign in_dbg_range = (cr_addr_in >= `DBG_RANGE_LO) && (cr_addr_in <= `DBG_RANGE_HI);
	assign cr_hit = cr_move_in && !in_dbg_range;

	always @(posedge clk_in) begin
		if (!nrst_in) begin
			sw_event_out <= 1'b0;
			cr_event_out <= 1'b0;
		end else begin
			// disabled: software debug instruction acts as a no-op
			sw_event_out <= enable_in && instr_valid_in && sw_hit;
			cr_event_out <= enable_in && instr_valid_in && cr_hit;
		end
	end
endmodule

//--- tb/core_debug_controller_props.sv
`timescale 1ns/1ns
module core_debug_controller_props (
	input wire clk_in,
	input wire nrst_in,
	input wire psel_in,
	input wire penable_in,
	input wire pwrite_in,
	input wire [11:0] paddr_in,
	input wire [31:0] pwdata_in,
	input wire [31:0] prdata_out,
	input wire pready_out,
	input wire pslverr_out,
	input wire break_out_out,
	input wire suspend_out_out,
	input wire halt_out,
	input wire trap_out,
	input wire bp_int_out,
	input wire debug_mode_out
);
	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (!nrst_in);
	wire setup = psel_in && !penable_in;
	sequence s_wr_st;
		psel_in && penable_in && pwrite_in && paddr_in == 12'h000;
	endsequence
	chk_rdy_pulse: assert property (setup |=> pready_out) else $error("ready missing");
	chk_rdy_cause: assert property (pready_out |-> $past(setup)) else $error("stray ready");
	chk_err_unmap: assert property (setup && !pwrite_in && paddr_in > 12'h014 |=>
		pslverr_out && prdata_out == 32'h0) else $error("unmapped read");
	chk_err_map: assert property (setup && paddr_in <= 12'h014 && paddr_in[1:0] == 2'h0 |=>
		!pslverr_out) else $error("mapped error");
	chk_dbg_mode: assert property (s_wr_st |=> ##1 debug_mode_out == $past(pwdata_in[0], 2))
		else $error("debug mode");
	chk_suspend_field_wr: assert property (s_wr_st |=> ##1 suspend_out_out == $past(pwdata_in[3], 2))
		else $error("suspend out");
	chk_halt_clr: assert property (s_wr_st ##0 pwdata_in[2:1] == 2'h2 |=> ##1 !halt_out)
		else $error("halt kept");
	chk_evt_off: assert property (!debug_mode_out [*3] |-> !trap_out && !bp_int_out && !break_out_out)
		else $error("event while off");
endmodule
bind core_debug_controller core_debug_controller_props u_props (.clk_in(clk_in), .nrst_in(nrst_in),
	.psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
	.pwdata_in(pwdata_in), .prdata_out(prdata_out), .pready_out(pready_out), .pslverr_out(pslverr_out),
	.break_out_out(break_out_out), .suspend_out_out(suspend_out_out), .halt_out(halt_out),
	.trap_out(trap_out), .bp_int_out(bp_int_out), .debug_mode_out(debug_mode_out));

//--- tb/core_debug_controller_tb.sv
`timescale 1ns/1ns
`include "dbg_ctrl_map.vh"
module core_debug_controller_tb;
	logic clk_in, nrst_in, psel, penable, pwrite, valid, lng, crm, trig, err;
	logic pready, pslverr, brk_in, suspend_field_in, brk_out, suspend_field_out, halt, trap, bpi, dmode;
	logic busy, ret, cnt;
	integer n_bpi = 0;
	logic [11:0] paddr;
	logic [15:0] craddr;
	logic [31:0] pwdata, prdata, instr, rd;
	integer n_errors = 0, n_compared = 0, n_trap = 0, brk_seen;
	core_debug_controller u_dut (.clk_in(clk_in), .nrst_in(nrst_in), .psel_in(psel), .penable_in(penable),
		.pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
		.pslverr_out(pslverr), .break_in_in(brk_in), .suspend_in_in(suspend_field_in), .trigger_event_in(trig),
		.noncancel_busy_in(busy), .instr_valid_in(valid), .instr_long_in(lng), .instr_in(instr),
		.cr_move_in(crm), .cr_addr_in(craddr), .instr_retired_in(ret), .break_out_out(brk_out),
		.suspend_out_out(suspend_field_out), .halt_out(halt), .trap_out(trap), .bp_int_out(bpi),
		.count_run_out(cnt), .debug_mode_out(dmode));
	debug_support_model u_sup (.clk_in(clk_in), .break_out_in(brk_out), .break_in_out(brk_in),
		.suspend_in_out(suspend_field_in), .brk_seen_out(brk_seen));
	initial begin
		clk_in = 1'b0;
		forever #25 clk_in = ~clk_in;
	end
	always @(posedge clk_in) if (trap === 1'b1) n_trap <= n_trap + 1;
	always @(posedge clk_in) if (bpi === 1'b1) n_bpi <= n_bpi + 1;
	////////////////////////////////////////////////////////////////
	task print_verdict;
		begin
			$display("compared=%0d errors=%0d", n_compared, n_errors);
			if (n_errors == 0 && n_compared > 0) $display("*** PASS ***");
			else $display("*** FAIL ***");
			$finish;
		end
	endtask
	task compare(input logic [31:0] got, input logic [31:0] exp);
		begin
			n_compared = n_compared + 1;
			if (got !== exp) begin
				n_errors = n_errors + 1;
				$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
			end
		end
	endtask
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		integer i;
		begin
			@(posedge clk_in);
			psel <= 1'b1;
			pwrite <= w;
			paddr <= a;
			pwdata <= d;
			@(posedge clk_in);
			penable <= 1'b1;
			i = 0;
			do begin
				@(posedge clk_in);
				i = i + 1;
			end while (pready !== 1'b1 && i < 20);
			if (i >= 20) begin
				n_errors = n_errors + 1;
				print_verdict;
			end
			rd = prdata;
			err = pslverr;
			psel <= 1'b0;
			penable <= 1'b0;
		end
	endtask
	task exec(input logic l, input logic [31:0] op, input logic m, input logic [15:0] a);
		begin
			@(posedge clk_in);
			valid <= 1'b1;
			lng <= l;
			instr <= op;
			crm <= m;
			craddr <= a;
			@(posedge clk_in);
			valid <= 1'b0;
			crm <= 1'b0;
			repeat (4) @(posedge clk_in);
		end
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		{nrst_in, psel, penable, pwrite, valid, lng, crm, trig, busy, ret, paddr, pwdata, instr, craddr} = '0;
		repeat (2) @(posedge clk_in);
		nrst_in <= 1'b1;
		apb(0, 12'h000, 0); compare(rd, 32'h0);
		apb(0, 12'h018, 0); compare({rd[30:0], err}, 32'h1);
		exec(0, `SW_DBG_SHORT, 0, 0);
		exec(0, 0, 1, 16'h1234);
		apb(0, 12'h000, 0); compare(rd, 32'h0);
		apb(1, 12'h000, 32'h1);
		apb(1, 12'h008, 32'h1b);
		apb(1, 12'h00c, 32'h24);
		compare(dmode, 1);
		exec(0, `SW_DBG_SHORT, 0, 0);
		apb(0, 12'h000, 0); compare(rd, 32'h229);
		exec(1, `SW_DBG_LONG, 0, 0);
		apb(0, 12'h000, 0); compare(rd, 32'h239);
		compare(n_trap, 2);
		compare(brk_seen, 2);
		apb(1, 12'h000, 32'h1);
		apb(0, 12'h000, 0); compare(rd, 32'h211);
		compare(suspend_field_out, 0);
		exec(0, 0, 1, `DBG_RANGE_LO);
		exec(0, 0, 1, `DBG_RANGE_HI);
		apb(0, 12'h000, 0); compare(rd, 32'h211);
		exec(0, 0, 1, 16'h1234);
		apb(0, 12'h000, 0); compare(rd, 32'h331);
		compare(n_bpi, 1);
		compare(cnt, 1);
		apb(1, 12'h010, 32'h0);
		@(posedge clk_in) trig <= 1'b1;
		@(posedge clk_in) trig <= 1'b0;
		repeat (4) @(posedge clk_in);
		apb(0, 12'h000, 0); compare(rd, 32'h421);
		apb(1, 12'h004, 32'h2);
		fork
			u_sup.hold_line(0, 30);
			begin
				repeat (8) @(posedge clk_in);
				compare(halt, 1);
				apb(0, 12'h000, 0); compare(rd, 32'h123);
				apb(1, 12'h000, 32'h5);
				repeat (2) @(posedge clk_in);
				compare(halt, 0);
			end
		join
		apb(0, 12'h000, 0); compare(rd, 32'h101);
		busy <= 1'b1;
		fork
			u_sup.hold_line(1, 10);
			begin
				repeat (8) @(posedge clk_in);
				compare(halt, 0);
				busy <= 1'b0;
				repeat (3) @(posedge clk_in);
				compare(halt, 1);
			end
		join
		apb(1, 12'h000, 32'h5);
		apb(1, 12'h014, 32'h1);
		@(posedge clk_in) ret <= 1'b1;
		@(posedge clk_in) ret <= 1'b0;
		repeat (2) @(posedge clk_in);
		compare(halt, 1);
		apb(1, 12'h000, 32'h4);
		exec(0, `SW_DBG_SHORT, 0, 0);
		compare(n_trap, 2);
		print_verdict;
	end
endmodule

//--- tb/debug_support_model.sv
`timescale 1ns/1ns
module debug_support_model (
	input wire clk_in,
	input wire break_out_in,
	output reg break_in_out,
	output reg suspend_in_out,
	output integer brk_seen_out
);
	initial begin
		break_in_out = 1'b0;
		suspend_in_out = 1'b0;
		brk_seen_out = 0;
	end
	always @(posedge clk_in) if (break_out_in === 1'b1) brk_seen_out <= brk_seen_out + 1;
	// long hold on purpose: a level must still count as one request
	task hold_line(input logic sel, input integer n);
		begin
			@(posedge clk_in);
			if (sel) suspend_in_out <= 1'b1;
			else break_in_out <= 1'b1;
			repeat (n) @(posedge clk_in);
			break_in_out <= 1'b0;
			suspend_in_out <= 1'b0;
		end
	endtask
endmodule
